// *** rtl/hsg_pkg.sv ***
// Purpose: Shared constants for the high-side gate command block.
// Assumes: One 32-bit classic Wishbone slave, one aligned word per register.
// Notes: Offsets are byte addresses.
package hsg_pkg;
    localparam int HSG_CHANNELS = 7;
    localparam int HSG_SEL_W = 2;
    localparam int HSG_ADR_W = 4;
    localparam int HSG_DAT_W = 32;
    // Channels that own a drive-enable override, zero based.
    localparam int HSG_OVR_CH_A = 4;
    localparam int HSG_OVR_CH_B = 6;
    // Register byte offsets.
    localparam logic [HSG_ADR_W-1:0] HSG_CTRL_OFS = 4'h0;
    localparam logic [HSG_ADR_W-1:0] HSG_RISE_OFS = 4'h4;
    localparam logic [HSG_ADR_W-1:0] HSG_FALL_OFS = 4'h8;
    localparam logic [HSG_ADR_W-1:0] HSG_STAT_OFS = 4'hc;
    // Control register fields.
    localparam int HSG_CTRL_BOOST_CUT = 0;
    localparam int HSG_CTRL_CLK_CUT = 1;
    localparam int HSG_CTRL_BOOST_MON = 2;
    localparam int HSG_CTRL_OVR_A = 3;
    localparam int HSG_CTRL_OVR_B = 4;
    localparam int HSG_CTRL_W = 5;
    localparam logic [HSG_CTRL_W-1:0] HSG_CTRL_RST = 5'h00;
    // Status register fields.
    localparam int HSG_STAT_CMD = 0;
    localparam int HSG_STAT_PRED_LOW = 8;
    localparam int HSG_STAT_LOGIC_LOW = 9;
    localparam int HSG_STAT_BOOST_LOW = 10;
    localparam int HSG_STAT_CLK_LOST = 11;
    localparam int HSG_STAT_DRIVER_ENABLE_INPUT = 12;
    // Strength codes: fastest to slowest.
    localparam logic [HSG_SEL_W-1:0] HSG_SLEW_300 = 2'h0;
    localparam logic [HSG_SEL_W-1:0] HSG_SLEW_50 = 2'h1;
    localparam logic [HSG_SEL_W-1:0] HSG_SLEW_25 = 2'h2;
    localparam logic [HSG_SEL_W-1:0] HSG_SLEW_12P5 = 2'h3;
    localparam logic [HSG_SEL_W-1:0] HSG_SLEW_RST = HSG_SLEW_300;
    localparam logic [HSG_DAT_W-1:0] HSG_RD_UNMAPPED = 32'h0000_0000;
endpackage

// *** rtl/hsg_chan.sv ***
// Purpose: Gate command decision for one high-side channel.
// Assumes: All inputs are already in the system clock domain.
// Notes: Purely combinational; the caller registers the result.
module hsg_chan
    import hsg_pkg::*;
#(
    parameter bit HAS_OVR = 1'b0
) (
    // Request and conditions
    input wire logic req,
    input wire logic blocked,
    input wire logic driver_enable_input,
    input wire logic ovr,
    // Result
    output logic cmd
);
    wire ovr_live;
    wire enable_path;

    // Channels without an override never see one, whatever is wired in.
    assign ovr_live = HAS_OVR ? ovr : 1'b0;
    assign enable_path = driver_enable_input | ovr_live;
    assign cmd = req & ~blocked & enable_path;
endmodule

// *** rtl/hsg_top.sv ***
// Purpose: Command logic for seven high-side gate pre-drivers.
// Assumes: Supply flags, lock and drive-enable come from pins and are resynchronised.
// Notes: Gate outputs are gated directly by reset, and by drive-enable on every channel whose override is clear, for a safe off state.
//
// Functional notes
// - Seven independent, separately configured high-side channels.
// - Gate command follows request unless blocked.
// - Predriver supply low forces all gates off.
// - Logic supply low forces all gates off.
// - Enabled boost cut-off with boost low: off.
// - Clock-loss cut-off off at reset, optional.
// - Drive-enable low turns off non-overridden channels.
// - Only channels five and seven have override.
// - Command high drives gate toward bootstrap.
// - Command low drives gate toward source.
// - Two-bit strength select, four slew settings.
// - Rising and falling strengths set separately.
// - Rising strength write also updates falling strength.
// - Reset, or drive-enable low on non-overridden channels, forces gates off immediately.
// - No drain-source monitoring in low-side use.
// - Software sets strengths through bus registers.
// - Boost low flag only while monitor enabled.
//
// The Wishbone register port and the register offsets are this design's own decisions.
module hsg_top
    import hsg_pkg::*;
#(
    parameter int N_CH = HSG_CHANNELS
) (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RESETN,
    // Wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [HSG_ADR_W-1:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [HSG_DAT_W-1:0] WB_DAT_I,
    output logic [HSG_DAT_W-1:0] WB_DAT_O,
    output logic WB_ACK_O,
    // Channel requests from channel logic
    input wire logic [N_CH-1:0] CHANNEL_REQUEST,
    // Supply and clock condition pins
    input wire logic PREDRIVER_SUPPLY_LOW,
    input wire logic LOGIC_SUPPLY_LOW,
    input wire logic BOOST_BELOW_THRESHOLD,
    input wire logic PLL_LOCKED,
    input wire logic DRIVER_ENABLE_INPUT,
    // Gate stage controls
    output logic [N_CH-1:0] GATE_PULL_UP,
    output logic [N_CH-1:0] GATE_PULL_DOWN,
    output logic [2*N_CH-1:0] RISE_STRENGTH,
    output logic [2*N_CH-1:0] FALL_STRENGTH
);
    localparam int SW = HSG_SEL_W * N_CH;
    localparam int NSYNC = 5;
    localparam int S_PRED = 0;
    localparam int S_LOGIC = 1;
    localparam int S_BOOST = 2;
    localparam int S_LOCK = 3;
    localparam int S_DRV = 4;

    if (N_CH <= HSG_OVR_CH_B || SW > 16) begin : g_bad_width
        $error("hsg_top: N_CH must be 7 or 8.");
    end

    // Write data merged through byte enables on the low two lanes.
    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [HSG_DAT_W-1:0] wr,
                                            input logic [3:0] sel);
        logic [15:0] res;
        res = old_v;
        if (sel[0]) begin
            res[7:0] = wr[7:0];
        end
        if (sel[1]) begin
            res[15:8] = wr[15:8];
        end
        return res;
    endfunction

    // Pin synchroniser. The first stage feeds only the second.
    logic [NSYNC-1:0] sync1_r;
    logic [NSYNC-1:0] sync2_r;
    wire [NSYNC-1:0] pins_raw;

    assign pins_raw = {DRIVER_ENABLE_INPUT, PLL_LOCKED, BOOST_BELOW_THRESHOLD,
                       LOGIC_SUPPLY_LOW, PREDRIVER_SUPPLY_LOW};

    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= pins_raw;
            sync2_r <= sync1_r;
        end
    end

    wire pred_low;
    wire logic_low;
    wire boost_below;
    wire pll_locked;
    wire driver_enable_input_s;

    assign pred_low = sync2_r[S_PRED];
    assign logic_low = sync2_r[S_LOGIC];
    assign boost_below = sync2_r[S_BOOST];
    assign pll_locked = sync2_r[S_LOCK];
    assign driver_enable_input_s = sync2_r[S_DRV];

    // Registers.
    logic [HSG_CTRL_W-1:0] ctrl_r;
    logic [HSG_CTRL_W-1:0] ctrl_nxt;
    logic [SW-1:0] rise_r;
    logic [SW-1:0] rise_nxt;
    logic [SW-1:0] fall_r;
    logic [SW-1:0] fall_nxt;
    logic [N_CH-1:0] cmd_r;
    logic [N_CH-1:0] cmd_nxt;
    logic ack_r;
    logic [HSG_DAT_W-1:0] rdata_r;

    // Bus decode.
    wire req_new;
    wire wr_en;
    wire hit_ctrl;
    wire hit_rise;
    wire hit_fall;
    wire hit_stat;
    wire [15:0] ctrl_ext;
    wire [15:0] rise_ext;
    wire [15:0] fall_ext;
    wire [15:0] ctrl_wr;
    wire [15:0] rise_wr;
    wire [15:0] fall_wr;

    assign req_new = WB_CYC_I & WB_STB_I & ~ack_r;
    assign wr_en = req_new & WB_WE_I;
    assign hit_ctrl = (WB_ADR_I == HSG_CTRL_OFS);
    assign hit_rise = (WB_ADR_I == HSG_RISE_OFS);
    assign hit_fall = (WB_ADR_I == HSG_FALL_OFS);
    assign hit_stat = (WB_ADR_I == HSG_STAT_OFS);
    assign ctrl_ext = 16'(ctrl_r);
    assign rise_ext = 16'(rise_r);
    assign fall_ext = 16'(fall_r);
    assign ctrl_wr = merge16(ctrl_ext, WB_DAT_I, WB_SEL_I);
    assign rise_wr = merge16(rise_ext, WB_DAT_I, WB_SEL_I);
    assign fall_wr = merge16(fall_ext, WB_DAT_I, WB_SEL_I);

    // Software reaches every configuration bit here rather than over a serial port.
    assign ctrl_nxt = (wr_en && hit_ctrl) ? ctrl_wr[HSG_CTRL_W-1:0] : ctrl_r;
    assign rise_nxt = (wr_en && hit_rise) ? rise_wr[SW-1:0] : rise_r;

    // A rising-edge write carries the same code to the falling edge so the absolute
    // slew rate matches; a later falling write can still set it apart.
    assign fall_nxt = (wr_en && hit_rise) ? rise_wr[SW-1:0] :
                      (wr_en && hit_fall) ? fall_wr[SW-1:0] : fall_r;

    // Conditions common to all channels.
    wire boost_low_flag;
    wire boost_block;
    wire clock_lost;
    wire clock_block;
    wire blocked_all;
    wire [N_CH-1:0] ovr_vec;
    wire [N_CH-1:0] cmd_comb;

    assign boost_low_flag = boost_below & ctrl_r[HSG_CTRL_BOOST_MON];
    assign boost_block = boost_low_flag & ctrl_r[HSG_CTRL_BOOST_CUT];
    assign clock_lost = ~pll_locked;
    // The cut-off bit resets clear, so a missing clock is harmless until enabled.
    assign clock_block = clock_lost & ctrl_r[HSG_CTRL_CLK_CUT];
    assign blocked_all = pred_low | logic_low | boost_block | clock_block;

    // Only two positions of the override vector can ever be set.
    generate
        for (genvar k = 0; k < N_CH; k++) begin : g_ovr
            if (k == HSG_OVR_CH_A) begin : g_a
                assign ovr_vec[k] = ctrl_r[HSG_CTRL_OVR_A];
            end else if (k == HSG_OVR_CH_B) begin : g_b
                assign ovr_vec[k] = ctrl_r[HSG_CTRL_OVR_B];
            end else begin : g_none
                assign ovr_vec[k] = 1'b0;
            end
        end
    endgenerate

    // One independent decision per channel.
    generate
        for (genvar c = 0; c < N_CH; c++) begin : g_ch
            hsg_chan #(
                .HAS_OVR(c == HSG_OVR_CH_A || c == HSG_OVR_CH_B)
            ) u_chan (
                .req(CHANNEL_REQUEST[c]),
                .blocked(blocked_all),
                .driver_enable_input(driver_enable_input_s),
                .ovr(ovr_vec[c]),
                .cmd(cmd_comb[c])
            );
        end
    endgenerate

    assign cmd_nxt = cmd_comb;

    // Read mux.
    wire [HSG_DAT_W-1:0] stat_word;
    wire [HSG_DAT_W-1:0] rd_mux;

    assign stat_word = HSG_DAT_W'(cmd_r) << HSG_STAT_CMD
                     | HSG_DAT_W'(pred_low) << HSG_STAT_PRED_LOW
                     | HSG_DAT_W'(logic_low) << HSG_STAT_LOGIC_LOW
                     | HSG_DAT_W'(boost_low_flag) << HSG_STAT_BOOST_LOW
                     | HSG_DAT_W'(clock_lost) << HSG_STAT_CLK_LOST
                     | HSG_DAT_W'(driver_enable_input_s) << HSG_STAT_DRIVER_ENABLE_INPUT;
    assign rd_mux = hit_ctrl ? HSG_DAT_W'(ctrl_r) :
                    hit_rise ? HSG_DAT_W'(rise_r) :
                    hit_fall ? HSG_DAT_W'(fall_r) :
                    hit_stat ? stat_word : HSG_RD_UNMAPPED;

    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            ctrl_r <= HSG_CTRL_RST;
            rise_r <= {N_CH{HSG_SLEW_RST}};
            fall_r <= {N_CH{HSG_SLEW_RST}};
        end else begin
            ctrl_r <= ctrl_nxt;
            rise_r <= rise_nxt;
            fall_r <= fall_nxt;
        end
    end

    // Unmapped addresses are still acknowledged; writes there change nothing.
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            ack_r <= 1'b0;
            rdata_r <= HSG_RD_UNMAPPED;
        end else begin
            ack_r <= req_new;
            rdata_r <= req_new ? rd_mux : rdata_r;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            cmd_r <= '0;
        end else begin
            cmd_r <= cmd_nxt;
        end
    end

    // The registered command lags the pins by the synchroniser, so reset and the
    // raw drive-enable also gate the outputs directly; override channels skip the
    // drive-enable term but keep the reset term.
    wire [N_CH-1:0] fast_enable;
    wire [N_CH-1:0] gate_on;

    assign fast_enable = ({N_CH{DRIVER_ENABLE_INPUT}} | ovr_vec) & {N_CH{RESETN}};
    assign gate_on = cmd_r & fast_enable;

    assign GATE_PULL_UP = gate_on;
    assign GATE_PULL_DOWN = ~gate_on;
    assign RISE_STRENGTH = rise_r;
    assign FALL_STRENGTH = fall_r;
    assign WB_ACK_O = ack_r;
    assign WB_DAT_O = rdata_r;

    // This block has no drain-source comparators, so a channel wired as a low-side
    // switch needs no special handling here.
endmodule

// *** test/hsg_gate_model.sv ***
// Purpose: Gate level seen at the external MOSFETs.
// Assumes: Pull-up and pull-down are never both active.
// Notes: With no drive the bleed resistor holds the gate at its source.
module hsg_gate_model #(
    parameter int N = 7
) (
    // Gate stage controls
    input wire logic [N-1:0] pull_up,
    input wire logic [N-1:0] pull_down,
    // Gate level
    output logic [N-1:0] gate_on
);
    assign gate_on = pull_up & ~pull_down;
endmodule

// *** test/hsg_sva.sv ***
// Purpose: Port assertions for the gate command block.
// Assumes: One clock, synchronous active-low reset.
// Notes: Override bits are internal, so channels 5 and 7 are masked.
module hsg_sva
    import hsg_pkg::*;
#(
    parameter int N_CH = HSG_CHANNELS
) (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RESETN,
    // Bus
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [HSG_ADR_W-1:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [HSG_DAT_W-1:0] WB_DAT_I,
    input wire logic [HSG_DAT_W-1:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    // Pins and gate controls
    input wire logic [N_CH-1:0] CHANNEL_REQUEST,
    input wire logic PREDRIVER_SUPPLY_LOW,
    input wire logic LOGIC_SUPPLY_LOW,
    input wire logic DRIVER_ENABLE_INPUT,
    input wire logic [N_CH-1:0] GATE_PULL_UP,
    input wire logic [N_CH-1:0] GATE_PULL_DOWN,
    input wire logic [2*N_CH-1:0] RISE_STRENGTH,
    input wire logic [2*N_CH-1:0] FALL_STRENGTH
);
    localparam logic [N_CH-1:0] OVR_M = (N_CH'(1) << HSG_OVR_CH_A) | (N_CH'(1) << HSG_OVR_CH_B);
    wire logic rise_wr = WB_STB_I && WB_WE_I && WB_ADR_I == HSG_RISE_OFS && WB_SEL_I[1:0] == 2'h3;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RESETN);
    a_reset_safe: assert property (disable iff (1'b0) !RESETN |-> GATE_PULL_UP == '0)
        else $error("gate on in reset");
    a_pull_pair: assert property (GATE_PULL_DOWN == ~GATE_PULL_UP)
        else $error("pull pair clash");
    a_req_gate: assert property ((GATE_PULL_UP & ~$past(CHANNEL_REQUEST)) == '0)
        else $error("gate on without request");
    a_drv_off: assert property (!DRIVER_ENABLE_INPUT |-> (GATE_PULL_UP & ~OVR_M) == '0)
        else $error("gate on with drive off");
    a_pred_off: assert property (PREDRIVER_SUPPLY_LOW [*3] |=> GATE_PULL_UP == '0)
        else $error("gate on, predriver low");
    a_logic_off: assert property (LOGIC_SUPPLY_LOW [*3] |=> GATE_PULL_UP == '0)
        else $error("gate on, logic low");
    a_rise_copy: assert property (rise_wr && WB_ACK_O |->
        FALL_STRENGTH == RISE_STRENGTH && RISE_STRENGTH == WB_DAT_I[2*N_CH-1:0])
        else $error("rise write not copied");
    a_ack_once: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack too long");
    a_ack_time: assert property ($rose(WB_STB_I) |=> WB_ACK_O)
        else $error("ack late");
    a_unmap_zero: assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I[1:0] != 2'h0
        |-> WB_DAT_O == '0)
        else $error("unmapped read not zero");
    c_ovr_on: cover property (!DRIVER_ENABLE_INPUT && GATE_PULL_UP != '0);
    c_rise_wr: cover property (rise_wr && WB_ACK_O);
    c_pred_off: cover property (PREDRIVER_SUPPLY_LOW [*3]);
endmodule

// *** test/high_side_gate_command_logic_test.sv ***
// Purpose: Self-checking bench for the gate command block.
// Assumes: Bus answer one cycle after the taking edge; pins synchronised in 2 edges, gates follow on the 3rd.
// Notes: Inputs change by non-blocking assignment just after a rising edge.
module high_side_gate_command_logic_test import hsg_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, ack;
    logic pred = 0, lgc = 0, bst = 0, lock = 1, den = 1;
    logic [3:0] adr = '0, sel = '0;
    logic [31:0] dw = '0, dr, q;
    logic [6:0] req = '0, pu, pd, gate;
    logic [13:0] rs, fs;
    int fail_count = 0, n_tests = 0;

    hsg_top uut (.CLOCK(clk), .RESETN(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dw), .WB_DAT_O(dr), .WB_ACK_O(ack),
        .CHANNEL_REQUEST(req), .PREDRIVER_SUPPLY_LOW(pred), .LOGIC_SUPPLY_LOW(lgc),
        .BOOST_BELOW_THRESHOLD(bst), .PLL_LOCKED(lock), .DRIVER_ENABLE_INPUT(den),
        .GATE_PULL_UP(pu), .GATE_PULL_DOWN(pd), .RISE_STRENGTH(rs), .FALL_STRENGTH(fs));
    hsg_gate_model #(.N(7)) u_gate (.pull_up(pu), .pull_down(pd), .gate_on(gate));

    initial begin
        forever #20 clk = ~clk;
    end

    task automatic print_verdict();
        if (fail_count == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Holds the request until ack is sampled; a lost ack ends the run.
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        dw <= d;
        sel <= 4'hf;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = dr;
        cyc <= 0;
        stb <= 0;
        if (ack !== 1'b1) begin
            $display("ERROR %0t: bus timeout", $time);
            fail_count++;
            print_verdict();
        end
    endtask

    task automatic t_reset();
        chk(32'(pd), 32'h7f);
        chk(32'(rs | fs), 32'h0);
        bus(0, HSG_CTRL_OFS, '0);
        chk(q, 32'h0);
        bus(0, 4'h2, '0);
        chk(q, HSG_RD_UNMAPPED);
    endtask

    task automatic t_chan();
        for (int c = 0; c < 7; c++) begin
            @(posedge clk);
            req <= 7'h1 << c;
            tick(1);
            chk(32'(pu), 32'(7'h1 << c));
            chk(32'(gate), 32'(7'h1 << c));
        end
        @(posedge clk);
        req <= '0;
        tick(1);
        chk(32'(gate), 32'h0);
    endtask

    task automatic t_block();
        @(posedge clk);
        req <= 7'h7f;
        pred <= 1;
        tick(3);
        chk(32'(pu), 32'h0);
        @(posedge clk);
        pred <= 0;
        lgc <= 1;
        tick(3);
        chk(32'(pu), 32'h0);
        @(posedge clk);
        lgc <= 0;
        bst <= 1;
        lock <= 0;
        tick(3);
        chk(32'(pu), 32'h7f);
        bus(1, HSG_CTRL_OFS, 32'h1);
        tick(2);
        chk(32'(pu), 32'h7f);
        bus(1, HSG_CTRL_OFS, 32'h5);
        tick(2);
        chk(32'(pu), 32'h0);
        bus(0, HSG_STAT_OFS, '0);
        chk(32'(q[HSG_STAT_BOOST_LOW]), 32'h1);
        bus(1, HSG_CTRL_OFS, 32'h2);
        tick(2);
        chk(32'(pu), 32'h0);
        bus(0, HSG_STAT_OFS, '0);
        chk(32'(q[HSG_STAT_CLK_LOST]), 32'h1);
        lock <= 1;
        bst <= 0;
    endtask

    task automatic t_drv();
        bus(1, HSG_CTRL_OFS, 32'h0);
        den <= 0;
        #1;
        chk(32'(pu), 32'h0);
        bus(1, HSG_CTRL_OFS, 32'h18);
        tick(3);
        chk(32'(pu), 32'h50);
        @(posedge clk);
        pred <= 1;
        tick(3);
        chk(32'(pu), 32'h0);
        @(posedge clk);
        pred <= 0;
        den <= 1;
        tick(3);
        chk(32'(pu), 32'h7f);
        @(posedge clk);
        rst_n <= 0;
        #1;
        chk(32'(pu), 32'h0);
        tick(5);
        @(posedge clk);
        rst_n <= 1;
        bus(0, HSG_CTRL_OFS, '0);
        chk(q, 32'h0);
    endtask

    task automatic t_slew();
        bus(1, HSG_RISE_OFS, 32'h24e4);
        chk(32'(rs), 32'h24e4);
        chk(32'(fs), 32'h24e4);
        bus(1, HSG_FALL_OFS, 32'h1b1b);
        chk(32'({rs, fs}), 32'({14'h24e4, 14'h1b1b}));
        bus(0, HSG_RISE_OFS, '0);
        chk(q, 32'h24e4);
    endtask

    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1;
        tick(1);
        t_reset();
        t_chan();
        t_block();
        t_drv();
        t_slew();
        print_verdict();
    end
endmodule

bind hsg_top hsg_sva #(.N_CH(N_CH)) u_sva (.CLOCK(CLOCK), .RESETN(RESETN),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
    .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
    .CHANNEL_REQUEST(CHANNEL_REQUEST), .PREDRIVER_SUPPLY_LOW(PREDRIVER_SUPPLY_LOW),
    .LOGIC_SUPPLY_LOW(LOGIC_SUPPLY_LOW), .DRIVER_ENABLE_INPUT(DRIVER_ENABLE_INPUT),
    .GATE_PULL_UP(GATE_PULL_UP), .GATE_PULL_DOWN(GATE_PULL_DOWN),
    .RISE_STRENGTH(RISE_STRENGTH), .FALL_STRENGTH(FALL_STRENGTH));
